//--- ftm_defines.vh
`ifndef FTM_DEFINES_VH
`define FTM_DEFINES_VH

// APB register byte offsets
`define FTM_REG_CTRL 8'h00
`define FTM_REG_STAT 8'h04
`define FTM_REG_UA 8'h08

// Control bit positions and reset value
`define FTM_CTRL_RSV 0
`define FTM_CTRL_STOP 1
`define FTM_CTRL_RST 2'h0

// Status bit positions
`define FTM_STAT_ACA 8
`define FTM_STAT_FLT 9
`define FTM_STAT_BUSY 11

// Unit attention register fields
`define FTM_UA_CLR_POS 4

// Task management functions on the request port
`define FTM_TMF_ABORT_SET 3'h1
`define FTM_TMF_CLEAR_SET 3'h2
`define FTM_TMF_TGT_RESET 3'h3
`define FTM_TMF_LUN_RESET 3'h4
`define FTM_TMF_TERMINATE 3'h5
`define FTM_TMF_CLEAR_ACA 3'h6

// Task management response codes
`define FTM_RSP_DONE 8'h00
`define FTM_RSP_REJECT 8'h04
`define FTM_RSP_FAILURE 8'h05

// Basic link service reply fields
`define FTM_RJT_LOGICAL 8'h03
`define FTM_RJT_BAD_XID 8'h03
`define FTM_RXID_NONE 16'hffff
`define FTM_SEQ_ID_INVALID 8'h00
`define FTM_LOW_SEQ_CNT 16'h0000
`define FTM_HIGH_SEQ_CNT 16'hffff

// SCSI status, sense key and additional sense codes
`define FTM_ST_GOOD 8'h00
`define FTM_ST_CHECK 8'h02
`define FTM_ST_TSF 8'h28
`define FTM_ST_ACA_ACTIVE 8'h30
`define FTM_SK_NONE 4'h0
`define FTM_SK_ILLEGAL 4'h5
`define FTM_ASC_NONE 8'h00
`define FTM_ASC_BAD_OP 8'h20
`define FTM_ASC_BAD_FIELD 8'h24
`define FTM_SNS_LEN 8'h12

// Opcodes named by the command decoder
`define FTM_OP_FORMAT 8'h04
`define FTM_OP_READ10 8'h28
`define FTM_OP_WRITE10 8'h2a

`endif

//--- ftm_task_mem.v
`timescale 1ns/1ps
`default_nettype none

module ftm_task_mem (
   input wire clock,
   input wire nrst,
   input wire we,
   input wire [2:0] waddr,
   input wire [81:0] wdata,
   input wire [2:0] raddr,
   output reg [81:0] rdata
);

   reg [81:0] mem [0:7];

   // Array has no reset: read data is only used while the entry's valid bit is set
   always @(posedge clock) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata <= 82'h0;
      end else begin
         rdata <= mem[raddr];
      end
   end

endmodule

`default_nettype wire

//--- ftm_handler.v
// How it works
// RULE1: Abort request kills matching task only
// RULE2: Initiator recovers open exchanges after success
// RULE3: Initiator may abort without sequence initiative
// RULE4: Abort uses open or unused sequence id
// RULE5: Abort count is last plus one, else zero
// RULE6: Abort carries own ox, rx FFFFh until assigned
// RULE7: Abort frame marks initiator sequence context
// RULE8: Reject only when assigned pair is unknown
// RULE9: Reject: logical error, bad id pair, last
// RULE10: Accept header echoes ids, last, recipient context
// RULE11: Accept payload: invalid seq id, 0000h..FFFFh
// RULE12: Abort task set kills requester's tasks
// RULE13: Terminate task answered function rejected
// RULE14: Clear ACA answered function rejected
// RULE15: Target reset clears all, attention to everyone
// RULE16: Clear task set, attention to other owners
// RULE17: Logical unit reset equals target reset
// RULE18: Task tag is sid, did, ox, rx
// RULE19: Check condition freezes queue, others ACA ACTIVE
// RULE20: NACA zero only; faulted initiator resumes queue
// RULE21: Check condition returns sense with length
// RULE22: Decode supported opcodes and service actions
// RULE23: Management response codes 00h, 04h, 05h
// RULE24: Unknown opcode gives illegal request check
//
// Our own choices: the APB register port and the register offsets.

`timescale 1ns/1ps
`default_nettype none
`include "ftm_defines.vh"

module ftm_handler (
   input wire clock,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire abts_valid,
   input wire [23:0] abts_sid,
   input wire [23:0] abts_did,
   input wire [15:0] abts_ox,
   input wire [15:0] abts_rx,
   input wire tmf_valid,
   input wire [2:0] tmf_fn,
   input wire [1:0] tmf_init,
   input wire [15:0] tmf_ox,
   input wire cmd_valid,
   input wire [1:0] cmd_init,
   input wire [23:0] cmd_sid,
   input wire [23:0] cmd_did,
   input wire [15:0] cmd_ox,
   input wire [7:0] cmd_opcode,
   input wire [4:0] cmd_sa,
   input wire cmd_naca,
   input wire done_valid,
   input wire [2:0] done_idx,
   output reg req_ready,
   output reg ba_valid,
   output reg ba_reject,
   output reg [15:0] ba_ox,
   output reg [15:0] ba_rx,
   output reg ba_last,
   output reg ba_ctx_recip,
   output reg [7:0] ba_reason,
   output reg [7:0] ba_expl,
   output reg [7:0] ba_seqid_vld,
   output reg [15:0] ba_low_cnt,
   output reg [15:0] ba_high_cnt,
   output reg rsp_valid,
   output reg rsp_tmf,
   output reg [15:0] rsp_ox,
   output reg [15:0] rsp_rx,
   output reg [7:0] rsp_code,
   output reg [7:0] rsp_status,
   output reg [7:0] rsp_sns_len,
   output reg [3:0] rsp_key,
   output reg [7:0] rsp_asc,
   output reg aca_active,
   output reg rsv_held
);

   localparam [1:0] S_IDLE = 2'b00;
   localparam [1:0] S_READ = 2'b01;
   localparam [1:0] S_CMP = 2'b10;
   localparam [1:0] S_FIN = 2'b11;

   ////////////////////////////////////////////////////////////////////////////

   function supported;
      input [7:0] op;
      input [4:0] sa;
      begin
         case (op)
            8'h00, 8'h01, 8'h03, `FTM_OP_FORMAT, 8'h07, 8'h08, 8'h0a, 8'h12,
            8'h15, 8'h16, 8'h17, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h25,
            `FTM_OP_READ10, `FTM_OP_WRITE10, 8'h2e, 8'h2f, 8'h34, 8'h35,
            8'h37, 8'h3b, 8'h3c, 8'h3e, 8'h3f, 8'h41, 8'h42, 8'h4c, 8'h4d,
            8'h55, 8'h56, 8'h57, 8'h5a, 8'h5e, 8'h5f, 8'h88, 8'h8a, 8'h8e,
            8'h8f, 8'h91, 8'h93, 8'ha0, 8'ha8, 8'haa, 8'hae, 8'haf,
            8'hb7: supported = 1'b1;
            8'h7f: supported = (sa >= 5'h09) && (sa <= 5'h0d);
            8'h9e: supported = (sa == 5'h10);
            8'ha3: supported = (sa == 5'h05) || (sa == 5'h0c) || (sa == 5'h0d);
            8'ha4: supported = (sa == 5'h06);
            default: supported = 1'b0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg job_tmf_reg;
   reg [2:0] idx_reg;
   reg [7:0] valid_reg;
   reg [7:0] valid_next;
   reg hit_reg;
   reg part_reg;
   reg [23:0] q_sid_reg;
   reg [23:0] q_did_reg;
   reg [15:0] q_ox_reg;
   reg [15:0] q_rx_reg;
   reg [2:0] q_fn_reg;
   reg [1:0] q_init_reg;
   reg [1:0] fault_reg;
   reg stop_reg;
   reg [3:0] ua_reg;
   reg [3:0] uac_reg;
   reg [3:0] ua_set;
   reg [3:0] uac_set;
   reg kill;
   reg [2:0] free_idx;
   reg free_found;
   reg [31:0] rd_val;
   reg addr_ok;
   integer i;

   wire [81:0] mem_rdata;
   wire [1:0] owner = mem_rdata[81:80];
   wire slot_live = valid_reg[idx_reg];
   wire is_reset = (q_fn_reg == `FTM_TMF_TGT_RESET) || (q_fn_reg == `FTM_TMF_LUN_RESET);
   wire take_abts = req_ready & abts_valid;
   wire take_tmf = req_ready & tmf_valid & ~abts_valid;
   wire take_cmd = req_ready & cmd_valid & ~abts_valid & ~tmf_valid;
   wire scan_fn = (tmf_fn == `FTM_TMF_ABORT_SET) || (tmf_fn == `FTM_TMF_CLEAR_SET) ||
                  (tmf_fn == `FTM_TMF_TGT_RESET) || (tmf_fn == `FTM_TMF_LUN_RESET);
   wire cmd_sup = supported(cmd_opcode, cmd_sa); // RULE22
   wire other_aca = aca_active & (cmd_init != fault_reg);
   wire cmd_store = take_cmd & ~other_aca & cmd_sup & ~cmd_naca & free_found;
   wire apb_wr = psel & penable & pready & pwrite;
   wire [15:0] new_rx = {13'h0, free_idx};

   // Tag layout {owner, sid, did, ox, rx}: the rx id is the slot number
   ftm_task_mem u_mem (
      .clock(clock),
      .nrst(nrst),
      .we(cmd_store),
      .waddr(free_idx),
      .wdata({cmd_init, cmd_sid, cmd_did, cmd_ox, new_rx}), // RULE18
      .raddr(idx_reg),
      .rdata(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////

   always @* begin
      free_found = 1'b0;
      free_idx = 3'h0;
      for (i = 7; i >= 0; i = i - 1) begin
         if (!valid_reg[i]) begin
            free_found = 1'b1;
            free_idx = i[2:0];
         end
      end
   end

   always @* begin
      kill = 1'b0;
      ua_set = 4'h0;
      uac_set = 4'h0;
      if (state_reg == S_CMP && slot_live) begin
         if (!job_tmf_reg) begin
            kill = (mem_rdata[79:0] == {q_sid_reg, q_did_reg, q_ox_reg, q_rx_reg}); // RULE1
         end else if (q_fn_reg == `FTM_TMF_ABORT_SET) begin
            kill = (owner == q_init_reg); // RULE12
         end else begin
            kill = 1'b1; // RULE15 RULE16
            if (q_fn_reg == `FTM_TMF_CLEAR_SET && owner != q_init_reg) begin
               ua_set[owner] = 1'b1; // RULE16
               uac_set[owner] = 1'b1;
            end
         end
      end
      if (state_reg == S_FIN && job_tmf_reg && is_reset) begin
         ua_set = 4'hf; // RULE15 RULE17
      end
   end

   always @* begin
      valid_next = valid_reg;
      if (done_valid) begin
         valid_next[done_idx] = 1'b0;
      end
      if (cmd_store) begin
         valid_next[free_idx] = 1'b1;
      end
      if (kill) begin
         valid_next[idx_reg] = 1'b0;
      end
   end

   always @* begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            if (take_abts || (take_tmf && scan_fn)) begin
               state_next = S_READ;
            end
         end
         S_READ: begin
            state_next = S_CMP;
         end
         S_CMP: begin
            state_next = (idx_reg == 3'h7) ? S_FIN : S_READ;
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   always @* begin
      rd_val = 32'h0;
      addr_ok = 1'b1;
      if (paddr == `FTM_REG_CTRL) begin
         rd_val[`FTM_CTRL_RSV] = rsv_held;
         rd_val[`FTM_CTRL_STOP] = stop_reg;
      end else if (paddr == `FTM_REG_STAT) begin
         rd_val[7:0] = valid_reg;
         rd_val[`FTM_STAT_ACA] = aca_active;
         rd_val[`FTM_STAT_FLT +: 2] = fault_reg;
         rd_val[`FTM_STAT_BUSY] = (state_reg != S_IDLE);
      end else if (paddr == `FTM_REG_UA) begin
         rd_val[3:0] = ua_reg;
         rd_val[`FTM_UA_CLR_POS +: 4] = uac_reg;
      end else begin
         addr_ok = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         {prdata, pready, pslverr} <= 34'h0;
         state_reg <= S_IDLE;
         valid_reg <= 8'h0;
         {job_tmf_reg, idx_reg, hit_reg, part_reg} <= 6'h0;
         {q_sid_reg, q_did_reg, q_ox_reg, q_rx_reg, q_fn_reg, q_init_reg} <= 85'h0;
         {fault_reg, stop_reg, ua_reg, uac_reg} <= 11'h0;
         {req_ready, aca_active, rsv_held} <= 3'h0;
         {ba_valid, ba_reject, ba_ox, ba_rx, ba_last, ba_ctx_recip} <= 36'h0;
         {ba_reason, ba_expl, ba_seqid_vld, ba_low_cnt, ba_high_cnt} <= 56'h0;
         {rsp_valid, rsp_tmf, rsp_ox, rsp_rx, rsp_code, rsp_status} <= 50'h0;
         {rsp_sns_len, rsp_key, rsp_asc} <= 20'h0;
      end else begin
         // Zero-wait APB: data is captured in setup, pready rises for access
         pready <= psel & ~penable;
         if (psel & ~penable) begin
            prdata <= rd_val;
            pslverr <= ~addr_ok;
         end
         if (apb_wr && paddr == `FTM_REG_CTRL) begin
            rsv_held <= pwdata[`FTM_CTRL_RSV];
            stop_reg <= pwdata[`FTM_CTRL_STOP];
         end
         // Write one to clear; a new attention in the same cycle survives
         if (apb_wr && paddr == `FTM_REG_UA) begin
            ua_reg <= (ua_reg & ~pwdata[3:0]) | ua_set;
            uac_reg <= (uac_reg & ~pwdata[`FTM_UA_CLR_POS +: 4]) | uac_set;
         end else begin
            ua_reg <= ua_reg | ua_set;
            uac_reg <= uac_reg | uac_set;
         end
         valid_reg <= valid_next;
         state_reg <= state_next;
         req_ready <= (state_next == S_IDLE) & ~stop_reg;
         ba_valid <= 1'b0;
         rsp_valid <= 1'b0;

         if (take_abts) begin
            job_tmf_reg <= 1'b0;
            idx_reg <= 3'h0;
            hit_reg <= 1'b0;
            part_reg <= 1'b0;
            q_sid_reg <= abts_sid;
            q_did_reg <= abts_did;
            q_ox_reg <= abts_ox;
            q_rx_reg <= abts_rx;
         end else if (take_tmf) begin
            q_fn_reg <= tmf_fn;
            q_init_reg <= tmf_init;
            q_ox_reg <= tmf_ox;
            job_tmf_reg <= 1'b1;
            idx_reg <= 3'h0;
            if (!scan_fn) begin
               // Terminate, clear ACA and unknown functions are not carried out
               rsp_valid <= 1'b1; // RULE13 RULE14
               rsp_tmf <= 1'b1;
               rsp_ox <= tmf_ox;
               rsp_rx <= `FTM_RXID_NONE;
               rsp_code <= `FTM_RSP_REJECT; // RULE23
               rsp_status <= `FTM_ST_GOOD;
               {rsp_sns_len, rsp_key, rsp_asc} <= 20'h0;
            end
         end else if (take_cmd) begin
            rsp_valid <= 1'b1;
            rsp_tmf <= 1'b0;
            rsp_ox <= cmd_ox;
            rsp_rx <= cmd_store ? new_rx : `FTM_RXID_NONE;
            rsp_code <= `FTM_RSP_DONE;
            {rsp_sns_len, rsp_key, rsp_asc} <= 20'h0;
            if (other_aca) begin
               rsp_status <= `FTM_ST_ACA_ACTIVE; // RULE19
            end else begin
               aca_active <= 1'b0; // RULE20
               if (!cmd_sup || cmd_naca) begin
                  // A set NACA bit on a supported opcode is refused like a bad opcode, but with the invalid field ASC
                  rsp_status <= `FTM_ST_CHECK; // RULE24 RULE20
                  rsp_key <= `FTM_SK_ILLEGAL;
                  rsp_asc <= cmd_sup ? `FTM_ASC_BAD_FIELD : `FTM_ASC_BAD_OP;
                  rsp_sns_len <= `FTM_SNS_LEN; // RULE21
                  aca_active <= 1'b1; // RULE19
                  fault_reg <= cmd_init;
               end else if (!free_found) begin
                  rsp_status <= `FTM_ST_TSF;
               end else begin
                  rsp_status <= `FTM_ST_GOOD;
               end
            end
         end

         if (state_reg == S_CMP) begin
            idx_reg <= idx_reg + 3'h1;
            if (kill) begin
               hit_reg <= 1'b1;
            end
            if (slot_live && mem_rdata[79:56] == q_sid_reg && mem_rdata[31:16] == q_ox_reg) begin
               part_reg <= 1'b1; // RULE8
            end
         end

         if (state_reg == S_FIN) begin
            if (!job_tmf_reg) begin
               ba_valid <= 1'b1;
               ba_ox <= q_ox_reg; // RULE10
               ba_rx <= q_rx_reg;
               ba_last <= 1'b1; // RULE9 RULE10
               ba_ctx_recip <= 1'b1;
               if (part_reg && !hit_reg) begin
                  ba_reject <= 1'b1; // RULE8
                  ba_reason <= `FTM_RJT_LOGICAL; // RULE9
                  ba_expl <= `FTM_RJT_BAD_XID;
                  {ba_seqid_vld, ba_low_cnt, ba_high_cnt} <= 40'h0;
               end else begin
                  ba_reject <= 1'b0;
                  {ba_reason, ba_expl} <= 16'h0;
                  ba_seqid_vld <= `FTM_SEQ_ID_INVALID; // RULE11
                  ba_low_cnt <= `FTM_LOW_SEQ_CNT;
                  ba_high_cnt <= `FTM_HIGH_SEQ_CNT;
               end
            end else begin
               rsp_valid <= 1'b1;
               rsp_tmf <= 1'b1;
               rsp_ox <= q_ox_reg;
               rsp_rx <= `FTM_RXID_NONE;
               rsp_code <= `FTM_RSP_DONE; // RULE23
               rsp_status <= `FTM_ST_GOOD;
               {rsp_sns_len, rsp_key, rsp_asc} <= 20'h0;
               if (is_reset) begin
                  // Power-on state, but the login table outside is left alone
                  rsv_held <= 1'b0; // RULE15 RULE17
                  aca_active <= 1'b0;
                  fault_reg <= 2'h0;
               end
            end
         end
      end
   end

endmodule

`default_nettype wire

//--- ftm_handler_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "ftm_defines.vh"
module ftm_handler_monitor (
   input wire logic clock,
   input wire logic nrst,
   input wire logic abts_valid,
   input wire logic [15:0] abts_ox,
   input wire logic [15:0] abts_rx,
   input wire logic tmf_valid,
   input wire logic [2:0] tmf_fn,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_opcode,
   input wire logic cmd_naca,
   input wire logic req_ready,
   input wire logic ba_valid,
   input wire logic ba_reject,
   input wire logic [15:0] ba_ox,
   input wire logic [15:0] ba_rx,
   input wire logic ba_last,
   input wire logic ba_ctx_recip,
   input wire logic [7:0] ba_reason,
   input wire logic [7:0] ba_expl,
   input wire logic [7:0] ba_seqid_vld,
   input wire logic [15:0] ba_low_cnt,
   input wire logic [15:0] ba_high_cnt,
   input wire logic rsp_valid,
   input wire logic rsp_tmf,
   input wire logic [7:0] rsp_code,
   input wire logic [7:0] rsp_status,
   input wire logic [7:0] rsp_sns_len,
   input wire logic [3:0] rsp_key,
   input wire logic [7:0] rsp_asc,
   input wire logic aca_active,
   input wire logic rsv_held
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////
   sequence s_abts;
      abts_valid && req_ready;
   endsequence
   sequence s_tmf;
      tmf_valid && req_ready && !abts_valid;
   endsequence
   sequence s_cmd;
      cmd_valid && req_ready && !abts_valid && !tmf_valid && !aca_active && !cmd_naca;
   endsequence
   sequence s_echo;
      ba_valid && (ba_reject || (ba_ox == $past(abts_ox, 18) && ba_rx == $past(abts_rx, 18)));
   endsequence
   ////////////////////////////////////////////////////////////////
   a_acc_echo_ids: assert property (s_abts |-> ##18 s_echo)
      else $error("accept ids not echoed");
   a_acc_hdr_pay: assert property (ba_valid && !ba_reject |-> ba_last && ba_ctx_recip
      && ba_seqid_vld == `FTM_SEQ_ID_INVALID && ba_low_cnt == `FTM_LOW_SEQ_CNT
      && ba_high_cnt == `FTM_HIGH_SEQ_CNT) else $error("accept fields wrong");
   a_rjt_reason: assert property (ba_valid && ba_reject |-> ba_last
      && ba_reason == `FTM_RJT_LOGICAL && ba_expl == `FTM_RJT_BAD_XID)
      else $error("reject fields wrong");
   a_tmf_refused: assert property (s_tmf ##0 (tmf_fn == `FTM_TMF_TERMINATE
      || tmf_fn == `FTM_TMF_CLEAR_ACA) |=> rsp_valid && rsp_tmf && rsp_code == `FTM_RSP_REJECT)
      else $error("function not rejected");
   a_tmf_zero_rest: assert property (rsp_valid && rsp_tmf |-> rsp_status == 8'h00
      && rsp_sns_len == 8'h00 && rsp_key == 4'h0 && rsp_asc == 8'h00 && (rsp_code
      == `FTM_RSP_DONE || rsp_code == `FTM_RSP_REJECT || rsp_code == `FTM_RSP_FAILURE))
      else $error("management response fields wrong");
   a_hard_reset: assert property (s_tmf ##0 (tmf_fn == `FTM_TMF_TGT_RESET
      || tmf_fn == `FTM_TMF_LUN_RESET) |-> ##18 (rsp_valid && rsp_code == `FTM_RSP_DONE)
      ##1 !rsv_held) else $error("reset kept reservation");
   a_sense_auto: assert property (rsp_valid && rsp_status == `FTM_ST_CHECK
      |-> rsp_sns_len == `FTM_SNS_LEN && rsp_key == `FTM_SK_ILLEGAL)
      else $error("sense length wrong");
   a_bad_opcode: assert property (s_cmd ##0 (cmd_opcode == 8'h02) |=> rsp_valid
      && rsp_status == `FTM_ST_CHECK && rsp_asc == `FTM_ASC_BAD_OP)
      else $error("unknown opcode accepted");
   a_read_decoded: assert property (s_cmd ##0 (cmd_opcode == `FTM_OP_READ10)
      |=> rsp_valid && (rsp_status == `FTM_ST_GOOD || rsp_status == `FTM_ST_TSF))
      else $error("read not decoded");
endmodule
bind ftm_handler ftm_handler_monitor u_mon (.*);
`default_nettype wire

//--- ftm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ftm_host_model (
   input wire logic clock,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic rsp_tmf,
   input wire logic [15:0] rsp_ox,
   input wire logic [15:0] rsp_rx,
   output logic abts_valid,
   output logic [23:0] abts_sid,
   output logic [23:0] abts_did,
   output logic [15:0] abts_ox,
   output logic [15:0] abts_rx,
   output logic tmf_valid,
   output logic [2:0] tmf_fn,
   output logic [1:0] tmf_init,
   output logic [15:0] tmf_ox,
   output logic cmd_valid,
   output logic [1:0] cmd_init,
   output logic [23:0] cmd_sid,
   output logic [23:0] cmd_did,
   output logic [15:0] cmd_ox,
   output logic [7:0] cmd_opcode,
   output logic [4:0] cmd_sa,
   output logic cmd_naca,
   output logic done_valid,
   output logic [2:0] done_idx
);
   // Arbitrary fabric address of the drive
   localparam logic [23:0] DID = 24'h0000ef;
   logic [15:0] rx_tab [0:15];
   initial begin
      {abts_valid, tmf_valid, cmd_valid, done_valid, done_idx} = '0;
      {abts_sid, abts_ox, abts_rx, tmf_fn, tmf_init, tmf_ox} = '0;
      {cmd_init, cmd_sid, cmd_ox, cmd_opcode, cmd_sa, cmd_naca} = '0;
      {abts_did, cmd_did} = {DID, DID};
      foreach (rx_tab[k]) rx_tab[k] = 16'hffff;
   end
   // Responder id becomes known only once the target has answered
   always @(posedge clock) begin
      if (rsp_valid && !rsp_tmf && rsp_rx != 16'hffff) rx_tab[rsp_ox[3:0]] <= rsp_rx;
   end
   ////////////////////////////////////////////////////////////////
   task automatic take(output bit ok);
      ok = 0;
      for (int n = 0; n < 60 && !ok; n++) begin
         @(negedge clock);
         ok = req_ready === 1'b1;
      end
      @(posedge clock);
   endtask
   task automatic send_cmd(input logic [1:0] i, input logic [7:0] op, input logic [4:0] sa,
         input logic naca, input logic [15:0] ox, output bit ok);
      @(posedge clock);
      {cmd_init, cmd_sid, cmd_ox, cmd_opcode, cmd_sa, cmd_naca, cmd_valid} <=
         {i, 22'h040000, i, ox, op, sa, naca, 1'b1};
      take(ok);
      {cmd_valid, cmd_ox, cmd_opcode} <= {1'b0, ~ox, ~op};
   endtask
   // No sequence is ever left open, so id and count start fresh; context is ours
   task automatic send_abts(input logic [1:0] i, input logic [15:0] ox, input bit bad,
         output logic [15:0] rx, output bit ok);
      rx = bad ? 16'h00ee : rx_tab[ox[3:0]];
      @(posedge clock);
      {abts_sid, abts_ox, abts_rx, abts_valid} <= {22'h040000, i, ox, rx, 1'b1};
      take(ok);
      {abts_valid, abts_ox, abts_rx} <= {1'b0, ~ox, ~rx};
   endtask
   task automatic send_tmf(input logic [2:0] f, input logic [1:0] i, input logic [15:0] ox,
         output bit ok);
      @(posedge clock);
      {tmf_fn, tmf_init, tmf_ox, tmf_valid} <= {f, i, ox, 1'b1};
      take(ok);
      {tmf_valid, tmf_ox} <= {1'b0, ~ox};
   endtask
endmodule
`default_nettype wire

//--- ftm_handler_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ftm_defines.vh"
module ftm_handler_tb_top;
   logic clock, nrst, psel, penable, pwrite, pready, pslverr, req_ready, ba_valid, ba_reject;
   logic ba_last, ba_ctx_recip, rsp_valid, rsp_tmf, aca_active, rsv_held, e;
   logic abts_valid, tmf_valid, cmd_valid, cmd_naca, done_valid;
   logic [1:0] tmf_init, cmd_init;
   logic [2:0] tmf_fn, done_idx;
   logic [3:0] rsp_key;
   logic [4:0] cmd_sa;
   logic [7:0] paddr, cmd_opcode, ba_reason, ba_expl, ba_seqid_vld, rsp_code, rsp_status;
   logic [7:0] rsp_sns_len, rsp_asc;
   logic [15:0] abts_ox, abts_rx, tmf_ox, cmd_ox, ba_ox, ba_rx, ba_low_cnt, ba_high_cnt;
   logic [15:0] rsp_ox, rsp_rx;
   logic [23:0] abts_sid, abts_did, cmd_sid, cmd_did;
   logic [31:0] pwdata, prdata, q;
   int n_errors = 0;
   int samples_checked = 0;
   ftm_handler dut (.*);
   ftm_host_model host (.*);
   initial begin
      clock = 0;
      forever #20 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("compares %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic tmo(input bit ok);
      if (!ok) begin
         n_errors++;
         $display("Error handshake expected answer seen none");
         final_report();
      end
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      bit ok;
      @(posedge clock);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clock);
      penable <= 1'b1;
      for (int n = 0; n < 20 && !ok; n++) begin
         @(negedge clock);
         ok = pready === 1'b1;
      end
      tmo(ok);
      {q, e} = {prdata, pslverr};
      @(posedge clock);
      {psel, penable} <= 2'b00;
   endtask
   task automatic wait_pulse(input bit ba);
      bit ok;
      for (int n = 0; n < 40 && !ok; n++) begin
         @(negedge clock);
         ok = ba ? ba_valid === 1'b1 : rsp_valid === 1'b1;
      end
      tmo(ok);
   endtask
   task automatic slots(input int n);
      apb(1'b0, `FTM_REG_STAT, 32'h0);
      chk("slots", n, $countones(q[7:0]));
   endtask
   task automatic cmd(input logic [1:0] i, input logic [7:0] op, input logic [4:0] sa,
         input logic naca, input logic [15:0] ox, input logic [7:0] st);
      bit ok;
      host.send_cmd(i, op, sa, naca, ox, ok);
      tmo(ok);
      wait_pulse(1'b0);
      chk("status", st, rsp_status);
      chk("rsp_ox", ox, rsp_ox);
   endtask
   task automatic abort(input logic [1:0] i, input logic [15:0] ox, input bit bad, input bit rj);
      bit ok;
      logic [15:0] rx;
      host.send_abts(i, ox, bad, rx, ok);
      tmo(ok);
      wait_pulse(1'b1);
      chk("ba_reject", rj, ba_reject);
      chk("ba_ids", {ox, rx}, {ba_ox, ba_rx});
   endtask
   task automatic tmf(input logic [2:0] f, input logic [1:0] i, input logic [7:0] c);
      bit ok;
      host.send_tmf(f, i, 16'h0020, ok);
      tmo(ok);
      wait_pulse(1'b0);
      chk("rsp_code", {1'b1, c}, {rsp_tmf, rsp_code});
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_regs;
      apb(1'b0, `FTM_REG_STAT, 32'h0);
      chk("stat", 32'h0, q);
      apb(1'b0, 8'h0c, 32'h0);
      chk("unmapped", 33'h1, {q, e});
      apb(1'b1, `FTM_REG_CTRL, 32'h3);
      apb(1'b0, `FTM_REG_CTRL, 32'h0);
      chk("ctrl", 32'h3, q);
      chk("stop", 0, req_ready);
      apb(1'b1, `FTM_REG_CTRL, 32'h1);
   endtask
   task automatic t_cmds;
      cmd(0, `FTM_OP_READ10, 0, 0, 1, `FTM_ST_GOOD);
      cmd(0, `FTM_OP_WRITE10, 0, 0, 2, `FTM_ST_GOOD);
      cmd(1, `FTM_OP_FORMAT, 0, 0, 3, `FTM_ST_GOOD);
      cmd(1, 8'h7f, 5'h09, 0, 4, `FTM_ST_GOOD);
      cmd(2, 8'h02, 0, 0, 5, `FTM_ST_CHECK);
      chk("sense", 20'h12520, {rsp_sns_len, rsp_key, rsp_asc});
      @(negedge clock);
      chk("aca", 1, aca_active);
      cmd(1, `FTM_OP_READ10, 0, 0, 6, `FTM_ST_ACA_ACTIVE);
      cmd(2, 8'h00, 0, 0, 7, `FTM_ST_GOOD);
      chk("aca", 0, aca_active);
      cmd(3, `FTM_OP_READ10, 0, 1, 8, `FTM_ST_CHECK);
      chk("asc", `FTM_ASC_BAD_FIELD, rsp_asc);
      cmd(3, 8'h12, 0, 0, 9, `FTM_ST_GOOD);
      slots(6);
   endtask
   task automatic t_abts;
      abort(0, 16'h1, 0, 0);
      slots(5);
      chk("rsv", 1, rsv_held);
      abort(0, 16'h2, 1, 1);
      slots(5);
      abort(0, 16'h55, 0, 0);
   endtask
   task automatic t_tmf;
      for (int f = 5; f < 8; f++) tmf(3'(f), 0, `FTM_RSP_REJECT);
      tmf(`FTM_TMF_ABORT_SET, 0, `FTM_RSP_DONE);
      slots(4);
      tmf(`FTM_TMF_CLEAR_SET, 1, `FTM_RSP_DONE);
      slots(0);
      apb(1'b0, `FTM_REG_UA, 32'h0);
      chk("ua_others", 4'hc, q[7:4]);
      chk("rsv", 1, rsv_held);
      abort(1, 16'h3, 0, 0);
   endtask
   // Reservation and a live task are re-armed so each reset has work to undo
   task automatic t_reset;
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, `FTM_REG_UA, 32'hff);
         apb(1'b1, `FTM_REG_CTRL, 32'h1);
         cmd(0, `FTM_OP_READ10, 0, 0, 16'h30, `FTM_ST_GOOD);
         tmf(k ? `FTM_TMF_LUN_RESET : `FTM_TMF_TGT_RESET, 0, `FTM_RSP_DONE);
         slots(0);
         chk("rsv", 0, rsv_held);
         apb(1'b0, `FTM_REG_UA, 32'h0);
         chk("ua_all", 4'hf, q[3:0]);
      end
   endtask
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      t_regs();
      t_cmds();
      t_abts();
      t_tmf();
      t_reset();
      final_report();
   end
endmodule
`default_nettype wire
